//--- inc/sto_pkg.sv
// Constants and types shared by the test-operation sequencer
package sto_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_JOG_SPD = 8'h08;
    localparam logic [7:0] REG_JOG_ACC = 8'h0C;
    localparam logic [7:0] REG_POS_SPD = 8'h10;
    localparam logic [7:0] REG_POS_ACC = 8'h14;
    localparam logic [7:0] REG_POS_DIST = 8'h18;
    localparam logic [7:0] REG_GEAR = 8'h1C;
    localparam logic [7:0] REG_STAT = 8'h20;
    localparam logic [7:0] REG_REMAIN = 8'h24;
    // Command bits of the control register
    localparam int C_JOG = 0;
    localparam int C_MLESS = 1;
    localparam int C_FWD = 2;
    localparam int C_REV = 3;
    localparam int C_PAUSE = 4;
    localparam int C_RESTART = 5;
    localparam int C_CLEAR = 6;
    localparam int C_FSTOP = 7;
    localparam int C_SWRUN = 8;
    localparam int C_SWCCW = 9;
    localparam int C_EXIT = 10;
    // Configuration bits
    localparam int F_AUTO_ON = 0;
    localparam int F_ZPHASE = 1;
    localparam int F_CMD_UNIT = 2;
    localparam logic [2:0] CFG_RST = 3'h0;
    // Reset values, limits and reference of speed (r/min) and time constant (ms)
    localparam logic [15:0] JOG_SPD_RST = 16'h00C8;
    localparam logic [15:0] JOG_ACC_RST = 16'h03E8;
    localparam logic [15:0] ACC_MAX = 16'hC350;
    localparam logic [15:0] SPD_MAX_DEF = 16'h1770;
    localparam logic [15:0] REF_SPD = 16'h0BB8;
    localparam logic [31:0] GEAR_RST = 32'h0001_0001;
    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int SET_HOLD_S = 2;
    localparam int SET_HOLD_CYC = SET_HOLD_S * CLK_HZ;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int SCREENS_DEF = 8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_JOG, ST_POS_RUN, ST_POS_ZSEEK, ST_POS_PAUSE, ST_MLESS
    } sto_state_t;
endpackage : sto_pkg

//--- inc/sto_ramp_if.sv
// Speed ramp request and answer between sequencer and ramp
`timescale 1ns/1ns
`default_nettype none
interface sto_ramp_if;
    logic [15:0] target;
    logic [15:0] accel;
    logic hard_stop;
    logic [15:0] speed;
    logic settled;
    modport ctl (output target, output accel, output hard_stop, input speed, input settled);
    modport ramp (input target, input accel, input hard_stop, output speed, output settled);
endinterface : sto_ramp_if
`default_nettype wire

//--- logic/sto_ramp.sv
// Speed ramp: steps speed toward target at the set time constant
`timescale 1ns/1ns
`default_nettype none
module sto_ramp #(
    parameter int MS_CYCLES = sto_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    sto_ramp_if.ramp rif
);
    import sto_pkg::*;

    logic [31:0] tick_q;
    logic [31:0] acc_q;
    logic [15:0] speed_q;
    logic tick;

    assign tick = (tick_q == 32'(MS_CYCLES - 1));
    assign rif.speed = speed_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_q <= 32'h0;
        end else begin
            tick_q <= tick ? 32'h0 : tick_q + 32'h1;
        end
    end

    // Reference speed is reached after one time constant, or after 3000 ms if that is longer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_q <= 16'h0;
            acc_q <= 32'h0;
        end else if (rif.hard_stop) begin
            speed_q <= 16'h0;
            acc_q <= 32'h0;
        end else if (rif.accel == 16'h0) begin
            speed_q <= rif.target;
            acc_q <= 32'h0;
        end else if (speed_q == rif.target) begin
            acc_q <= 32'h0;
        end else if (tick) begin
            if (acc_q + 32'(REF_SPD) >= 32'(rif.accel)) begin
                acc_q <= acc_q + 32'(REF_SPD) - 32'(rif.accel);
                speed_q <= (speed_q < rif.target) ? speed_q + 16'h1 : speed_q - 16'h1;
            end else begin
                acc_q <= acc_q + 32'(REF_SPD);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rif.settled <= 1'b1;
        end else begin
            rif.settled <= (speed_q == rif.target);
        end
    end
endmodule : sto_ramp
`default_nettype wire

//--- logic/sto_seq.sv
// Test-operation sequencer: jog, single positioning and motor-less modes
// How it works
// - Auto-on config forces both stroke ends on
// - Jog only without external command
// - Jog runs only while button held or software run set
// - Up is counter-clockwise, down is clockwise
// - Jog speed 200 r/min, clamped to maximum
// - Time constant 1000 ms, up to 50000
// - Link loss ramps software jog down
// - Mode press cycles screens, wraps to ready
// - Up/down never change status screen
// - Mode then set held 2 s ends jog
// - Positioning runs once per software request
// - Z-phase option seeks first index after distance
// - Unit selects gear-scaled or raw distance
// - Forward and reverse requests set direction
// - Pause accepted only while rotating
// - Restart accepted only while paused
// - Remaining clear accepted only while paused
// - Forced stop only while rotating, abrupt
// - Motor-less simulates run from external inputs
// - Motor-less entered servo-off, left by reset
// - No test mode entry while servo-on
`timescale 1ns/1ns
`default_nettype none
module sto_seq #(
    parameter int MS_CYCLES = sto_pkg::TICK_CYC,
    parameter int HOLD_CYCLES = sto_pkg::SET_HOLD_CYC,
    parameter int SCREENS = sto_pkg::SCREENS_DEF,
    parameter logic [15:0] SPD_MAX = sto_pkg::SPD_MAX_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic emergency_stop_input_i,
    input wire logic forward_stroke_end_i,
    input wire logic reverse_stroke_end_i,
    input wire logic servo_on_input_i,
    input wire logic ext_cmd_active_i,
    input wire logic ext_dir_ccw_i,
    input wire logic [15:0] ext_speed_i,
    input wire logic btn_mode_i,
    input wire logic btn_up_i,
    input wire logic btn_down_i,
    input wire logic btn_set_i,
    input wire logic link_alive_i,
    input wire logic enc_pulse_i,
    input wire logic enc_index_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [15:0] motor_speed_o,
    output logic motor_ccw_o,
    output logic motor_run_o,
    output logic power_en_o,
    output sto_pkg::sto_state_t mode_o,
    output logic [3:0] screen_o
);
    import sto_pkg::*;

    function automatic logic [15:0] sto_clamp(input logic [31:0] v, input logic [15:0] lim);
        sto_clamp = (v > 32'(lim)) ? lim : v[15:0];
    endfunction : sto_clamp

    function automatic logic [31:0] sto_scale(input logic [31:0] d, input logic [31:0] g);
        logic [47:0] p;
        p = 48'(d) * 48'(g[31:16]);
        sto_scale = (g[15:0] == 16'h0) ? d : 32'(p / 48'(g[15:0]));
    endfunction : sto_scale

    ////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////
    // Registers
    sto_state_t state_q;
    logic [2:0] cfg_q;
    logic [15:0] jog_spd_q, jog_acc_q, pos_spd_q, pos_acc_q;
    logic [31:0] dist_q, gear_q, remain_q;
    logic sw_run_q, sw_ccw_q, dir_ccw_q, hard_stop_q, mode_prev_q, armed_q;
    logic [3:0] screen_q;
    logic [31:0] hold_q;
    logic wr_ctrl;
    logic [10:0] cmd;

    assign wr_ctrl = wr_i && (addr_i == REG_CTRL);
    assign cmd = wr_ctrl ? wdata_i[10:0] : 11'h0;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RST;
            jog_spd_q <= JOG_SPD_RST;
            jog_acc_q <= JOG_ACC_RST;
            pos_spd_q <= JOG_SPD_RST;
            pos_acc_q <= JOG_ACC_RST;
            dist_q <= 32'h0;
            gear_q <= GEAR_RST;
        end else if (wr_i) begin
            case (addr_i)
                REG_CFG: cfg_q <= wdata_i[2:0];
                REG_JOG_SPD: jog_spd_q <= sto_clamp(wdata_i, SPD_MAX);
                REG_JOG_ACC: jog_acc_q <= sto_clamp(wdata_i, ACC_MAX);
                REG_POS_SPD: pos_spd_q <= sto_clamp(wdata_i, SPD_MAX);
                REG_POS_ACC: pos_acc_q <= sto_clamp(wdata_i, ACC_MAX);
                REG_POS_DIST: dist_q <= wdata_i;
                REG_GEAR: gear_q <= wdata_i;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Permissives
    logic stroke_ok, jog_ok, pos_ok, mode_press, up_only, dn_only, panel_run;
    assign stroke_ok = cfg_q[F_AUTO_ON] | (forward_stroke_end_i & reverse_stroke_end_i);
    assign jog_ok = emergency_stop_input_i & stroke_ok & ~ext_cmd_active_i;
    assign pos_ok = emergency_stop_input_i & stroke_ok & ~ext_cmd_active_i;
    assign mode_press = btn_mode_i & ~mode_prev_q;
    assign up_only = btn_up_i & ~btn_down_i;
    assign dn_only = btn_down_i & ~btn_up_i;
    assign panel_run = up_only | dn_only;

    ////////////////////////////////////////////////////////////////
    // Software jog request
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_run_q <= 1'b0;
            sw_ccw_q <= 1'b0;
        end else if (state_q != ST_JOG || !link_alive_i) begin
            sw_run_q <= 1'b0;
        end else if (wr_ctrl) begin
            sw_run_q <= wdata_i[C_SWRUN];
            sw_ccw_q <= wdata_i[C_SWCCW];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode sequencing
    logic rotating, hold_done;
    assign rotating = (state_q == ST_POS_RUN) || (state_q == ST_POS_ZSEEK);
    assign hold_done = armed_q && btn_set_i && (hold_q == 32'(HOLD_CYCLES - 1));

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            remain_q <= 32'h0;
            hard_stop_q <= 1'b0;
        end else begin
            hard_stop_q <= ~emergency_stop_input_i;
            case (state_q)
                ST_IDLE: begin
                    if (!servo_on_input_i) begin
                        if (cmd[C_MLESS]) begin
                            state_q <= ST_MLESS;
                        end else if (cmd[C_JOG]) begin
                            state_q <= ST_JOG;
                        end else if ((cmd[C_FWD] | cmd[C_REV]) && pos_ok) begin
                            state_q <= ST_POS_RUN;
                            remain_q <= cfg_q[F_CMD_UNIT] ? sto_scale(dist_q, gear_q) : dist_q;
                        end
                    end
                end
                ST_JOG: begin
                    if (hold_done || cmd[C_EXIT]) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_POS_RUN, ST_POS_ZSEEK: begin
                    if (cmd[C_FSTOP]) begin
                        state_q <= ST_IDLE;
                        remain_q <= 32'h0;
                        hard_stop_q <= 1'b1;
                    end else if (cmd[C_PAUSE]) begin
                        state_q <= ST_POS_PAUSE;
                    end else if (cmd[C_EXIT]) begin
                        state_q <= ST_IDLE;
                        remain_q <= 32'h0;
                    end else if (state_q == ST_POS_ZSEEK) begin
                        if (enc_index_i) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (remain_q == 32'h0) begin
                        state_q <= cfg_q[F_ZPHASE] ? ST_POS_ZSEEK : ST_IDLE;
                    end else if (enc_pulse_i) begin
                        remain_q <= remain_q - 32'h1;
                    end
                end
                ST_POS_PAUSE: begin
                    if (cmd[C_CLEAR] || cmd[C_EXIT]) begin
                        state_q <= ST_IDLE;
                        remain_q <= 32'h0;
                    end else if (cmd[C_RESTART]) begin
                        state_q <= ST_POS_RUN;
                    end
                end
                ST_MLESS: state_q <= ST_MLESS;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Direction latched at positioning start
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dir_ccw_q <= 1'b0;
        end else if (state_q == ST_IDLE && cmd[C_FWD]) begin
            dir_ccw_q <= 1'b1;
        end else if (state_q == ST_IDLE && cmd[C_REV]) begin
            dir_ccw_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status screens and jog exit hold
    logic screen_mode;
    assign screen_mode = (state_q == ST_JOG) || (state_q == ST_MLESS);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_prev_q <= 1'b0;
            screen_q <= 4'h0;
        end else begin
            mode_prev_q <= btn_mode_i;
            // Only the mode button steps screens
            if (!screen_mode) begin
                screen_q <= 4'h0;
            end else if (mode_press) begin
                screen_q <= (screen_q == 4'(SCREENS)) ? 4'h0 : screen_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            hold_q <= 32'h0;
        end else if (state_q != ST_JOG) begin
            armed_q <= 1'b0;
            hold_q <= 32'h0;
        end else begin
            if (mode_press) begin
                armed_q <= 1'b1;
            end
            hold_q <= (armed_q && btn_set_i) ? hold_q + 32'h1 : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Ramp request
    sto_ramp_if rif ();
    sto_ramp #(.MS_CYCLES(MS_CYCLES)) u_ramp (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .rif(rif)
    );

    logic [15:0] target;
    logic [15:0] accel;
    logic want_ccw;
    always_comb begin
        target = 16'h0;
        accel = pos_acc_q;
        want_ccw = dir_ccw_q;
        case (state_q)
            ST_JOG: begin
                accel = jog_acc_q;
                if (jog_ok && panel_run) begin
                    target = jog_spd_q;
                    want_ccw = up_only;
                end else if (jog_ok && sw_run_q) begin
                    target = jog_spd_q;
                    want_ccw = sw_ccw_q;
                end
            end
            ST_POS_RUN, ST_POS_ZSEEK: target = pos_spd_q;
            ST_MLESS: begin
                if (servo_on_input_i && ext_cmd_active_i && emergency_stop_input_i) begin
                    target = ext_speed_i;
                    want_ccw = ext_dir_ccw_i;
                end
            end
            default: target = 16'h0;
        endcase
    end

    assign rif.target = target;
    assign rif.accel = accel;
    assign rif.hard_stop = hard_stop_q;
    assign motor_speed_o = rif.speed;

    ////////////////////////////////////////////////////////////////
    // Outputs; direction changes only at standstill
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            motor_ccw_o <= 1'b0;
            motor_run_o <= 1'b0;
            power_en_o <= 1'b0;
            mode_o <= ST_IDLE;
            screen_o <= 4'h0;
        end else begin
            if (rif.speed == 16'h0) begin
                motor_ccw_o <= want_ccw;
            end
            motor_run_o <= (rif.speed != 16'h0);
            power_en_o <= (state_q != ST_IDLE) && (state_q != ST_MLESS);
            mode_o <= state_q;
            screen_o <= screen_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register read
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                REG_CFG: rdata_o <= {29'h0, cfg_q};
                REG_JOG_SPD: rdata_o <= {16'h0, jog_spd_q};
                REG_JOG_ACC: rdata_o <= {16'h0, jog_acc_q};
                REG_POS_SPD: rdata_o <= {16'h0, pos_spd_q};
                REG_POS_ACC: rdata_o <= {16'h0, pos_acc_q};
                REG_POS_DIST: rdata_o <= dist_q;
                REG_GEAR: rdata_o <= gear_q;
                REG_STAT: rdata_o <= {rif.speed, 3'h0, rif.settled, sw_run_q, motor_ccw_o, armed_q, power_en_o,
                                      screen_q, 1'b0, state_q};
                REG_REMAIN: rdata_o <= remain_q;
                default: rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    sequence pos_run_s;
        (state_q == ST_POS_RUN) && cmd[C_FSTOP];
    endsequence
    sequence stopped_s;
        (state_q == ST_IDLE) && hard_stop_q;
    endsequence

    servo_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_IDLE) && servo_on_input_i |=> state_q == ST_IDLE)
        else $error("test mode entered with servo on");
    mless_stick_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        state_q == ST_MLESS |=> state_q == ST_MLESS [*8])
        else $error("motor-less mode left");
    jog_release_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_JOG) && !btn_up_i && !btn_down_i && !sw_run_q |-> rif.target == 16'h0)
        else $error("jog target without button");
    jog_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_JOG) && jog_ok && up_only && rif.speed == 16'h0 |=> motor_ccw_o)
        else $error("up button not counter-clockwise");
    ext_block_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_JOG) && ext_cmd_active_i |-> rif.target == 16'h0)
        else $error("jog ran under external command");
    pause_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        !rotating && state_q != ST_POS_PAUSE |=> state_q != ST_POS_PAUSE)
        else $error("pause taken while not rotating");
    restart_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_POS_PAUSE) && cmd[C_RESTART] && !cmd[C_CLEAR] && !cmd[C_EXIT] |=> state_q == ST_POS_RUN)
        else $error("restart not taken in pause");
    clear_dist_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_POS_PAUSE) && cmd[C_CLEAR] |=> (state_q == ST_IDLE) && (remain_q == 32'h0))
        else $error("remaining distance not cleared");
    fstop_hard_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        pos_run_s |=> stopped_s ##1 rif.speed == 16'h0)
        else $error("forced stop not abrupt");
    link_loss_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        sw_run_q && !link_alive_i |=> !sw_run_q)
        else $error("software jog kept after link loss");
    screen_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        screen_mode && mode_press && screen_q == 4'(SCREENS) |=> screen_q == 4'h0)
        else $error("screen cycle did not wrap");
    auto_on_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (state_q == ST_JOG) && cfg_q[F_AUTO_ON] && emergency_stop_input_i && !ext_cmd_active_i && up_only
        |-> rif.target == jog_spd_q)
        else $error("stroke auto-on ignored");
endmodule : sto_seq
`default_nettype wire

//--- verification/sto_panel_model.sv
// Operator side model: safety lines and scanned panel buttons
`timescale 1ns/1ns
`default_nettype none
module sto_panel_model (
    input wire logic clk_i,
    input wire logic strokes_i,
    input wire logic [3:0] hold_i,
    output logic emergency_stop_o,
    output logic fwd_o,
    output logic rev_o,
    output logic [3:0] btn_o
);
    assign emergency_stop_o = 1'b1;
    assign fwd_o = strokes_i;
    assign rev_o = strokes_i;
    ////////////////////////////////////////////////////////////
    // Buttons appear one scan later, like a real panel
    always_ff @(posedge clk_i) begin
        btn_o <= hold_i;
    end
endmodule : sto_panel_model
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the test-operation sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sto_pkg::*;
    localparam int SCR = 4;
    logic clk = 0, rst_n = 0, servo_on_input = 0, ext = 0, link = 1, enc = 0, wr = 0, rd = 0, stk = 1, idx = 0;
    logic emergency_stop_input, fsl, rsl, ccw, run, pwr;
    logic [3:0] hold = 4'h0, btn, scr;
    logic [15:0] espd = 16'h0000, spd;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v, s;
    sto_state_t mode;
    int failures = 0, samples_checked = 0;
    always #2 clk = ~clk;
    sto_panel_model PM (.clk_i(clk), .strokes_i(stk), .hold_i(hold), .emergency_stop_o(emergency_stop_input), .fwd_o(fsl),
        .rev_o(rsl), .btn_o(btn));
    sto_seq #(.MS_CYCLES(10), .HOLD_CYCLES(20), .SCREENS(SCR)) DUT (.clk_i(clk), .rst_n_i(rst_n),
        .emergency_stop_input_i(emergency_stop_input), .forward_stroke_end_i(fsl), .reverse_stroke_end_i(rsl),
        .servo_on_input_i(servo_on_input), .ext_cmd_active_i(ext), .ext_dir_ccw_i(espd[0]), .ext_speed_i(espd),
        .btn_mode_i(btn[0]), .btn_up_i(btn[1]), .btn_down_i(btn[2]), .btn_set_i(btn[3]),
        .link_alive_i(link), .enc_pulse_i(enc), .enc_index_i(idx), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .motor_speed_o(spd), .motor_ccw_o(ccw), .motor_run_o(run),
        .power_en_o(pwr), .mode_o(mode), .screen_o(scr));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] clampv(input logic [31:0] x, input logic [31:0] m);
        return (x > m) ? m : x;
    endfunction : clampv
    function automatic logic [31:0] pick(input int k);
        return (k == 0) ? 32'(mode) : (k == 1) ? 32'(spd) : 32'(run);
    endfunction : pick
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rdchk
    task automatic waitv(input int k, input logic [31:0] e);
        int n;
        n = 0;
        while (pick(k) !== e && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        chk(pick(k), e);
    endtask : waitv
    task automatic press(input int i, input int len);
        @(posedge clk);
        hold[i] <= 1'b1;
        repeat (len) @(posedge clk);
        hold[i] <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : press
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            enc <= 1'b1;
            @(posedge clk);
            enc <= 1'b0;
        end
    endtask : pulses
    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(49));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk(REG_JOG_SPD, 32'h0000_00C8);
        rdchk(REG_JOG_ACC, 32'h0000_03E8);
        rdchk(8'h3C, 32'h0000_0000);
        wr32(REG_JOG_ACC, 32'h0000_EA60);
        rdchk(REG_JOG_ACC, clampv(32'h0000_EA60, 32'(ACC_MAX)));
        wr32(REG_JOG_SPD, 32'h0000_FFFF);
        rdchk(REG_JOG_SPD, clampv(32'h0000_FFFF, 32'(SPD_MAX_DEF)));
        s = 32'h1 + $urandom % 900;
        wr32(REG_JOG_SPD, s);
        rdchk(REG_JOG_SPD, s);
        wr32(REG_JOG_ACC, 32'h0);
        servo_on_input <= 1'b1;
        wr32(REG_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        servo_on_input <= 1'b0;
        #1 chk(mode, ST_IDLE);
        wr32(REG_CTRL, 32'h1);
        waitv(0, ST_JOG);
        wr32(REG_CTRL, 32'h0000_0300);
        waitv(1, s);
        chk(ccw, 1);
        @(posedge clk);
        link <= 1'b0;
        waitv(1, 0);
        @(posedge clk);
        link <= 1'b1;
        ext <= 1'b1;
        hold[1] <= 1'b1;
        repeat (40) @(posedge clk);
        ext <= 1'b0;
        #1 chk(spd, 0);
        waitv(1, s);
        chk(ccw, 1);
        @(posedge clk);
        hold[1] <= 1'b0;
        waitv(1, 0);
        @(posedge clk);
        hold[2] <= 1'b1;
        waitv(1, s);
        chk(ccw, 0);
        @(posedge clk);
        hold[2] <= 1'b0;
        waitv(1, 0);
        press(0, 2);
        chk(scr, 1);
        press(1, 2);
        chk(scr, 1);
        repeat (SCR) press(0, 2);
        chk(scr, 0);
        press(0, 2);
        press(3, 30);
        waitv(0, ST_IDLE);
        wr32(REG_POS_DIST, 32'd10);
        wr32(REG_CTRL, 32'h4);
        waitv(0, ST_POS_RUN);
        pulses(3);
        rdchk(REG_REMAIN, 32'd7);
        wr32(REG_CTRL, 32'h20);
        @(posedge clk);
        #1 chk(mode, ST_POS_RUN);
        wr32(REG_CTRL, 32'h10);
        waitv(0, ST_POS_PAUSE);
        wr32(REG_CTRL, 32'h80);
        @(posedge clk);
        #1 chk(mode, ST_POS_PAUSE);
        wr32(REG_CTRL, 32'h20);
        waitv(0, ST_POS_RUN);
        pulses(7);
        waitv(0, ST_IDLE);
        stk <= 1'b0;
        wr32(REG_CFG, 32'h5);
        wr32(REG_GEAR, 32'h0002_0001);
        wr32(REG_POS_DIST, 32'd3);
        wr32(REG_CTRL, 32'h8);
        waitv(0, ST_POS_RUN);
        rdchk(REG_REMAIN, 32'd3 * 32'd2 / 32'd1);
        wr32(REG_CTRL, 32'h80);
        waitv(0, ST_IDLE);
        wr32(REG_CTRL, 32'h4);
        waitv(0, ST_POS_RUN);
        chk(ccw, 1);
        wr32(REG_CTRL, 32'h10);
        waitv(0, ST_POS_PAUSE);
        wr32(REG_CTRL, 32'h40);
        rdchk(REG_REMAIN, 32'h0);
        wr32(REG_CTRL, 32'h400);
        waitv(0, ST_IDLE);
        wr32(REG_CFG, 32'h3);
        wr32(REG_CTRL, 32'h4);
        pulses(3);
        waitv(0, ST_POS_ZSEEK);
        idx <= 1'b1;
        @(posedge clk);
        idx <= 1'b0;
        waitv(0, ST_IDLE);
        wr32(REG_CTRL, 32'h2);
        waitv(0, ST_MLESS);
        chk(pwr, 0);
        @(posedge clk);
        servo_on_input <= 1'b1;
        ext <= 1'b1;
        espd <= 16'h1 + 16'($urandom % 500);
        waitv(2, 1);
        wr32(REG_CTRL, 32'h400);
        @(posedge clk);
        #1 chk(mode, ST_MLESS);
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
